// >>> tag_map.svh
// Purpose: constants of the ticket version query and page read exchange
// Assumes: 125 MHz core clock, 13.56 MHz carrier for frame delay figures
// Notes: definitions only
`ifndef TAG_MAP_SVH
`define TAG_MAP_SVH

// ----------------------------------------------------------------
// command codes and reply layout
// ----------------------------------------------------------------
`define CMD_VERSION 8'h60
`define CMD_READ 8'h30
`define VERSION_LEN 5'd8
`define READ_LEN 5'd16
`define VERSION_HEADER 8'h00
`define STORE_SMALL 8'h0b
`define STORE_LARGE 8'h0e
`define NAK_ARG 4'h0
`define NAK_CRC 4'h1

// ----------------------------------------------------------------
// memory layout
// ----------------------------------------------------------------
`define LAST_SMALL 8'h13
`define LAST_LARGE 8'h28
`define PAGE_COUNT 41
`define PWD_BACK 8'h01
`define RX_MAX 5'd18
`define FIFO_DEPTH 4

// ----------------------------------------------------------------
// framing crc
// ----------------------------------------------------------------
`define CRC_INIT 16'h6363
`define CRC_POLY 16'h8408

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 64'd125000000
`define FC_HZ 64'd13560000
`define FDT_N 64'd9
`define FDT_CYC int'(((`FDT_N * 64'd128 + 64'd84) * `CLK_HZ + `FC_HZ - 64'd1) / `FC_HZ)
`define TIMEOUT_US 64'd5000
`define TIMEOUT_CYC int'(`TIMEOUT_US * `CLK_HZ / 64'd1000000)

`endif

// >>> tag_pkg.sv
// Purpose: shared types and helpers for both ends of the ticket link
// Assumes: constants come from tag_map.svh
// Notes: crc is the reflected type a crc, low byte sent first
`include "tag_map.svh"
package tag_pkg;

	// ----------------------------------------------------------------
	// link word and state types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic short_f;
		logic last;
		logic [7:0] data;
	} link_word_type;

	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_WAIT = 3'b010,
		C_SEND = 3'b100
	} card_state_type;

	typedef enum logic [2:0] {
		R_IDLE = 3'b001,
		R_SEND = 3'b010,
		R_WAIT = 3'b100
	} reader_state_type;

	typedef enum logic [1:0] {
		K_VER = 2'd0,
		K_READ = 2'd1,
		K_NAK = 2'd2
	} reply_kind_type;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// one byte through the crc, lsb first
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// next page inside the window that ends before lim
	function automatic logic [7:0] next_page(input logic [7:0] p, input logic [7:0] lim);
		return ((p + 8'h01) >= lim) ? 8'h00 : p + 8'h01;
	endfunction

endpackage

// >>> tag_link_if.sv
// Purpose: byte level link between reader and card
// Assumes: one clock, both ends synchronous to it
// Notes: rsp_short marks a four bit answer in data[3:0]
interface tag_link_if;
	logic cmd_valid;
	logic [7:0] cmd_data;
	logic cmd_last;
	logic cmd_err;
	logic rsp_valid;
	logic rsp_ready;
	logic [7:0] rsp_data;
	logic rsp_last;
	logic rsp_short;

	modport card (input cmd_valid, cmd_data, cmd_last, cmd_err, rsp_ready,
		output rsp_valid, rsp_data, rsp_last, rsp_short);
	modport reader (output cmd_valid, cmd_data, cmd_last, cmd_err, rsp_ready,
		input rsp_valid, rsp_data, rsp_last, rsp_short);
endinterface

// >>> tag_fifo.sv
// Purpose: small flop fifo with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full shows as in_ready low, empty as out_valid low
module tag_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] cnt;
	} fifo_reg_type;

	fifo_reg_type q, d;
	logic push, pop;

	// ----------------------------------------------------------------
	// flags and next state
	// ----------------------------------------------------------------
	assign in_ready = (q.cnt != CW'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// push and pop may share a cycle, count then stands still
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wr] = in_data;
			d.wr = q.wr + AW'(1);
		end
		if (pop) begin
			d.rd = q.rd + AW'(1);
		end
		d.cnt = q.cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

// >>> tag_card.sv
// Purpose: card end, answers version query and four page read
// Assumes: reader holds off a new command until the answer is complete
// Notes: page contents are loaded from the user side over load_*
// Summary of operation
// - version query is one byte plus crc
// - version reply is eight bytes plus crc
// - reply order header, vendor, type, subtype, versions, size, protocol
// - size byte upper seven bits hold exponent
// - size lsb set when between powers
// - size byte 0bh small, 0eh large
// - answer after frame delay nine, 5 ms timeout
// - read takes start page, returns four pages
// - unprotected start pages run 00h to last page
// - start page beyond range gets nak
// - pages past the last wrap to 00h
// - unauthenticated read at protected page gets nak
// - unauthenticated read wraps before protected page
// - authenticated read ignores protection
// - password pages always read as zeros
// - frames end in two byte crc
// - ack and nak go as four bit frames
// - invalid argument gives nak code 0h
// - parity or crc error gives nak code 1h
module tag_card
	import tag_pkg::*;
#(
	parameter logic LARGE = 1'b0,
	parameter logic [7:0] VENDOR_CODE = 8'ha5, // arbitrary value
	parameter logic [7:0] PRODUCT_TYPE = 8'h5c, // arbitrary value
	parameter logic [7:0] PRODUCT_SUBTYPE = 8'h3d, // arbitrary value
	parameter logic [7:0] MAJOR_VERSION = 8'h2e, // arbitrary value
	parameter logic [7:0] MINOR_VERSION = 8'h7b, // arbitrary value
	parameter logic [7:0] PROTOCOL_TYPE = 8'h69, // arbitrary value
	parameter int FDT_CYCLES = `FDT_CYC
) (
	input wire logic core_clk,
	input wire logic nrst,
	tag_link_if.card link,
	input wire logic authenticated,
	input wire logic [7:0] protection_start_page,
	input wire logic load_valid,
	input wire logic [7:0] load_page,
	input wire logic [31:0] load_data,
	output logic busy
);
	localparam logic [7:0] LAST = LARGE ? `LAST_LARGE : `LAST_SMALL;
	localparam logic [7:0] STORE = LARGE ? `STORE_LARGE : `STORE_SMALL;
	localparam logic [7:0] PWD_PAGE = LAST - `PWD_BACK;

	typedef struct packed {
		card_state_type st;
		logic [`PAGE_COUNT-1:0][31:0] mem;
		logic [2:0] rx_cnt;
		logic [7:0] cmd;
		logic [7:0] arg;
		logic [15:0] rx_crc;
		logic rx_bad;
		logic [15:0] wait_cnt;
		reply_kind_type kind;
		logic [3:0] nak_code;
		logic [4:0] idx;
		logic [7:0] page;
		logic [7:0] limit;
		logic [15:0] tx_crc;
		logic busy;
	} card_reg_type;

	card_reg_type q, d;
	link_word_type tx_word;
	logic tx_valid, tx_ready;
	logic [7:0] data_byte;
	logic [4:0] data_len;
	logic prot_on;
	link_word_type out_word;

	// ----------------------------------------------------------------
	// reply byte selection
	// ----------------------------------------------------------------
	function automatic logic [7:0] version_byte(input logic [2:0] i);
		logic [7:0] b;
		unique case (i)
			3'd0: b = `VERSION_HEADER;
			3'd1: b = VENDOR_CODE;
			3'd2: b = PRODUCT_TYPE;
			3'd3: b = PRODUCT_SUBTYPE;
			3'd4: b = MAJOR_VERSION;
			3'd5: b = MINOR_VERSION;
			3'd6: b = STORE;
			3'd7: b = PROTOCOL_TYPE;
		endcase
		return b;
	endfunction

	// password and its ack never leave the card
	function automatic logic [7:0] page_byte(input logic [7:0] p, input logic [1:0] i,
		input logic [`PAGE_COUNT-1:0][31:0] m);
		logic [31:0] w;
		w = m[p[5:0]];
		if (p >= PWD_PAGE) begin
			w = 32'h0000_0000;
		end
		return w[8*i +: 8];
	endfunction

	assign prot_on = !authenticated && (protection_start_page <= LAST);
	assign data_len = (q.kind == K_VER) ? `VERSION_LEN : `READ_LEN;
	assign data_byte = (q.kind == K_VER) ? version_byte(q.idx[2:0])
		: page_byte(q.page, q.idx[1:0], q.mem);
	assign busy = q.busy;

	// ----------------------------------------------------------------
	// receive, wait out the frame delay, then answer
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		tx_valid = 1'b0;
		tx_word = '0;
		if (load_valid && (load_page <= LAST)) begin
			d.mem[load_page[5:0]] = load_data;
		end
		unique case (q.st)
			C_IDLE: begin
				if (link.cmd_valid) begin
					d.rx_crc = crc_step(q.rx_crc, link.cmd_data);
					d.rx_bad = q.rx_bad | link.cmd_err;
					if (q.rx_cnt == 3'd0) begin
						d.cmd = link.cmd_data;
					end
					if (q.rx_cnt == 3'd1) begin
						d.arg = link.cmd_data;
					end
					if (q.rx_cnt != 3'd7) begin
						d.rx_cnt = q.rx_cnt + 3'd1;
					end
					if (link.cmd_last) begin
						d.st = C_WAIT;
						d.busy = 1'b1;
						d.wait_cnt = 16'h0000;
					end
				end
			end
			C_WAIT: begin
				// the decision waits for the delay so a late protection change still counts
				d.wait_cnt = q.wait_cnt + 16'h0001;
				if (q.wait_cnt >= 16'(FDT_CYCLES - 1)) begin
					d.st = C_SEND;
					d.idx = 5'd0;
					d.tx_crc = `CRC_INIT;
					d.kind = K_NAK;
					d.nak_code = `NAK_ARG;
					d.page = q.arg;
					d.limit = prot_on ? protection_start_page : LAST + 8'h01;
					if (q.rx_bad || q.rx_crc != 16'h0000 || q.rx_cnt < 3'd3) begin
						d.nak_code = `NAK_CRC;
					end else if (q.cmd == `CMD_VERSION) begin
						if (q.rx_cnt == 3'd3) begin
							d.kind = K_VER;
						end
					end else if (q.cmd == `CMD_READ) begin
						if (q.rx_cnt == 3'd4 && q.arg <= LAST
							&& !(prot_on && q.arg >= protection_start_page)) begin
							d.kind = K_READ;
						end
					end else begin
						// unknown commands stay silent
						d.st = C_IDLE;
						d.busy = 1'b0;
					end
					d.rx_cnt = 3'd0;
					d.rx_crc = `CRC_INIT;
					d.rx_bad = 1'b0;
				end
			end
			C_SEND: begin
				tx_valid = 1'b1;
				if (q.kind == K_NAK) begin
					tx_word = '{short_f: 1'b1, last: 1'b1, data: {4'h0, q.nak_code}};
				end else if (q.idx < data_len) begin
					tx_word.data = data_byte;
				end else if (q.idx == data_len) begin
					tx_word.data = q.tx_crc[7:0];
				end else begin
					tx_word.data = q.tx_crc[15:8];
					tx_word.last = 1'b1;
				end
				if (tx_ready) begin
					d.idx = q.idx + 5'd1;
					if (q.idx < data_len) begin
						d.tx_crc = crc_step(q.tx_crc, data_byte);
						if (q.idx[1:0] == 2'd3) begin
							d.page = next_page(q.page, q.limit);
						end
					end
					if (tx_word.last) begin
						d.st = C_IDLE;
						d.busy = 1'b0;
					end
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '{st: C_IDLE, rx_crc: `CRC_INIT, tx_crc: `CRC_INIT, kind: K_VER, default: '0};
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// answer buffer, stalls the sender when the reader holds off
	// ----------------------------------------------------------------
	tag_fifo #(.WIDTH($bits(link_word_type)), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.nrst(nrst),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_word),
		.out_valid(link.rsp_valid),
		.out_ready(link.rsp_ready),
		.out_data(out_word)
	);

	assign link.rsp_data = out_word.data;
	assign link.rsp_last = out_word.last;
	assign link.rsp_short = out_word.short_f;
endmodule

// >>> tag_reader.sv
// Purpose: reader end, sends version query or page read and collects the answer
// Assumes: one request at a time, next only after res_valid
// Notes: answers that arrive after a timeout are drained and dropped
module tag_reader
	import tag_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
	input wire logic core_clk,
	input wire logic nrst,
	tag_link_if.reader link,
	input wire logic req_valid,
	input wire logic req_read,
	input wire logic [7:0] req_page,
	input wire logic req_corrupt,
	input wire logic rx_hold,
	output logic req_ready,
	output logic res_valid,
	output logic res_nak,
	output logic [3:0] res_code,
	output logic res_timeout,
	output logic res_crc_err,
	output logic [4:0] res_len,
	output logic [127:0] res_data
);
	typedef struct packed {
		reader_state_type st;
		logic rd;
		logic [7:0] page;
		logic corrupt;
		logic [1:0] idx;
		logic [15:0] tx_crc;
		logic cmd_valid;
		logic [7:0] cmd_data;
		logic cmd_last;
		logic cmd_err;
		logic rsp_ready;
		logic [19:0] tmo;
		logic [17:0][7:0] buffer;
		logic [4:0] rx_cnt;
		logic [15:0] rx_crc;
		logic req_ready;
		logic res_valid;
		logic res_nak;
		logic [3:0] res_code;
		logic res_timeout;
		logic res_crc_err;
		logic [4:0] res_len;
	} reader_reg_type;

	reader_reg_type q, d;
	logic [7:0] b;
	logic [1:0] pay_last;
	logic [15:0] crc_next;

	assign link.cmd_valid = q.cmd_valid;
	assign link.cmd_data = q.cmd_data;
	assign link.cmd_last = q.cmd_last;
	assign link.cmd_err = q.cmd_err;
	assign link.rsp_ready = q.rsp_ready;
	assign req_ready = q.req_ready;
	assign res_valid = q.res_valid;
	assign res_nak = q.res_nak;
	assign res_code = q.res_code;
	assign res_timeout = q.res_timeout;
	assign res_crc_err = q.res_crc_err;
	assign res_len = q.res_len;
	assign res_data = q.buffer[15:0];

	// ----------------------------------------------------------------
	// command out, answer in
	// ----------------------------------------------------------------
	assign pay_last = q.rd ? 2'd1 : 2'd0;
	assign b = (q.idx == 2'd0) ? (q.rd ? `CMD_READ : `CMD_VERSION) : q.page;
	assign crc_next = crc_step(q.rx_crc, link.rsp_data);

	always_comb begin
		d = q;
		d.cmd_valid = 1'b0;
		d.cmd_last = 1'b0;
		d.cmd_err = 1'b0;
		d.res_valid = 1'b0;
		d.rsp_ready = !rx_hold; // late answers are drained even when idle
		unique case (q.st)
			R_IDLE: begin
				if (req_valid && q.req_ready) begin
					d.req_ready = 1'b0;
					d.rd = req_read;
					d.page = req_page;
					d.corrupt = req_corrupt;
					d.idx = 2'd0;
					d.tx_crc = `CRC_INIT;
					d.st = R_SEND;
				end
			end
			R_SEND: begin
				d.cmd_valid = 1'b1;
				d.idx = q.idx + 2'd1;
				if (q.idx <= pay_last) begin
					d.cmd_data = b;
					d.tx_crc = crc_step(q.tx_crc, b);
				end else if (q.idx == pay_last + 2'd1) begin
					d.cmd_data = q.tx_crc[7:0];
				end else begin
					d.cmd_data = q.tx_crc[15:8];
					d.cmd_last = 1'b1;
					d.cmd_err = q.corrupt;
					d.st = R_WAIT;
					d.tmo = 20'h00000;
					d.rx_cnt = 5'd0;
					d.rx_crc = `CRC_INIT;
				end
			end
			R_WAIT: begin
				d.tmo = q.tmo + 20'h00001;
				if (link.rsp_valid && q.rsp_ready) begin
					if (link.rsp_short) begin
						d.res_nak = 1'b1;
						d.res_code = link.rsp_data[3:0];
						d.res_crc_err = 1'b0;
						d.res_timeout = 1'b0;
						d.res_len = 5'd0;
						d.res_valid = 1'b1;
						d.req_ready = 1'b1;
						d.st = R_IDLE;
					end else begin
						if (q.rx_cnt < `RX_MAX) begin
							d.buffer[q.rx_cnt] = link.rsp_data;
							d.rx_cnt = q.rx_cnt + 5'd1;
						end
						d.rx_crc = crc_next;
						if (link.rsp_last) begin
							// residue is zero when data and crc agree
							d.res_crc_err = (crc_next != 16'h0000) || (q.rx_cnt < 5'd2);
							d.res_len = (q.rx_cnt < 5'd2) ? 5'd0 : q.rx_cnt - 5'd1;
							d.res_nak = 1'b0;
							d.res_timeout = 1'b0;
							d.res_valid = 1'b1;
							d.req_ready = 1'b1;
							d.st = R_IDLE;
						end
					end
				end else if (q.tmo >= 20'(TIMEOUT_CYCLES - 1)) begin
					d.res_timeout = 1'b1;
					d.res_nak = 1'b0;
					d.res_crc_err = 1'b0;
					d.res_len = 5'd0;
					d.res_valid = 1'b1;
					d.req_ready = 1'b1;
					d.st = R_IDLE;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '{st: R_IDLE, tx_crc: `CRC_INIT, rx_crc: `CRC_INIT, req_ready: 1'b1,
				default: '0};
		end else begin
			q <= d;
		end
	end
endmodule

// >>> tag_link_sva.sv
// Purpose: protocol checks on the link between reader and card
// Assumes: card built small, frame delay parameter 8, commands are 60h or 30h only
// Notes: instantiated beside the link interface, watches its signals only
module tag_link_sva (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_last,
	input wire logic cmd_err,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_last,
	input wire logic rsp_short
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// helper state
	// ----------------------------------------------------------------
	logic [4:0] wcnt_q;
	logic cmd_open_q;
	logic [7:0] code_q;
	logic take;

	// an answer word moves only when both sides agree
	assign take = rsp_valid && rsp_ready;

	// word count of the answer and first byte of the command it answers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wcnt_q <= 5'h00;
			cmd_open_q <= 1'b0;
			code_q <= 8'h00;
		end else begin
			if (take) wcnt_q <= rsp_last ? 5'h00 : wcnt_q + 5'h01;
			if (cmd_valid) cmd_open_q <= !cmd_last;
			if (cmd_valid && !cmd_open_q) code_q <= cmd_data;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	short_nak_form_a: assert property (rsp_valid && rsp_short |->
		rsp_last && rsp_data[7:1] == 7'h00)
		else $error("short answer not a lone nak word");
	nak_alone_a: assert property (take && wcnt_q != 5'h00 |-> !rsp_short)
		else $error("short word inside a data answer");
	answer_hold_a: assert property (rsp_valid && !rsp_ready |=>
		rsp_valid && $stable(rsp_data) && $stable(rsp_last) && $stable(rsp_short))
		else $error("answer word changed before it was taken");
	frame_delay_a: assert property (cmd_last |=> !rsp_valid [*8] ##1 !rsp_valid)
		else $error("answer earlier than the frame delay");
	answer_due_a: assert property (cmd_last |-> ##[10:300] rsp_valid)
		else $error("no answer after command");
	cmd_burst_a: assert property (cmd_valid && !cmd_last |=> cmd_valid)
		else $error("gap inside command frame");
	err_on_last_a: assert property (cmd_err |-> cmd_valid && cmd_last)
		else $error("error flag off the last byte");
	frame_len_a: assert property (take && rsp_last && !rsp_short |->
		wcnt_q == ((code_q == 8'h60) ? 5'd9 : 5'd17))
		else $error("answer length wrong");
	ver_header_a: assert property (take && wcnt_q == 5'h00 && code_q == 8'h60 && !rsp_short
		|-> rsp_data == 8'h00)
		else $error("version header byte wrong");
	ver_size_a: assert property (take && wcnt_q == 5'd6 && code_q == 8'h60 |->
		rsp_data == 8'h0b)
		else $error("storage size byte wrong");

	// main scenarios reached
	cover property (take && rsp_last && !rsp_short && code_q == 8'h60);
	cover property (take && rsp_last && !rsp_short && code_q == 8'h30);
	cover property (take && rsp_short);
	cover property (rsp_valid && !rsp_ready);
endmodule

// >>> tag_version_and_page_read_test.sv
// Purpose: reader and card joined over the link, driven from both user sides
// Assumes: small card, short frame delay and timeout parameters
// Notes: inputs change on the falling edge, results read there too
module tag_version_and_page_read_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic core_clk = 1'b0, nrst = 1'b0;
	logic req_valid = 1'b0, req_read = 1'b0, req_corrupt = 1'b0, rx_hold = 1'b0;
	logic [7:0] req_page = 8'h00, protection_start_page = 8'hff, load_page = 8'h00;
	logic authenticated = 1'b0, load_valid = 1'b0;
	logic [31:0] load_data = 32'h0;
	logic req_ready, res_valid, res_nak, res_timeout, res_crc_err, busy;
	logic [3:0] res_code;
	logic [4:0] res_len;
	logic [127:0] res_data;
	int error_cnt = 0, checked = 0, cyc = 0;
	// identity values are arbitrary
	localparam logic [63:0] VER = {8'h47, 8'h0b, 8'h2c, 8'h19, 8'h71, 8'h6e, 8'h5a, 8'h00};

	always #4 core_clk = ~core_clk;

	tag_link_if link();
	tag_reader #(.TIMEOUT_CYCLES(200)) tag_reader_inst (.core_clk(core_clk), .nrst(nrst),
		.link(link), .req_valid(req_valid), .req_read(req_read), .req_page(req_page),
		.req_corrupt(req_corrupt), .rx_hold(rx_hold), .req_ready(req_ready),
		.res_valid(res_valid), .res_nak(res_nak), .res_code(res_code),
		.res_timeout(res_timeout), .res_crc_err(res_crc_err), .res_len(res_len),
		.res_data(res_data));
	tag_card #(.LARGE(1'b0), .VENDOR_CODE(VER[15:8]), .PRODUCT_TYPE(VER[23:16]),
		.PRODUCT_SUBTYPE(VER[31:24]), .MAJOR_VERSION(VER[39:32]),
		.MINOR_VERSION(VER[47:40]), .PROTOCOL_TYPE(VER[63:56]), .FDT_CYCLES(8))
		tag_card_inst (.core_clk(core_clk), .nrst(nrst), .link(link),
		.authenticated(authenticated), .protection_start_page(protection_start_page),
		.load_valid(load_valid), .load_page(load_page), .load_data(load_data), .busy(busy));
	tag_link_sva tag_link_sva_inst (.core_clk(core_clk), .nrst(nrst),
		.cmd_valid(link.cmd_valid), .cmd_data(link.cmd_data), .cmd_last(link.cmd_last),
		.cmd_err(link.cmd_err), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
		.rsp_data(link.rsp_data), .rsp_last(link.rsp_last), .rsp_short(link.rsp_short));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic test_done();
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_data(input logic [127:0] got, input logic [127:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// distinct content per page so a wrong page or byte order shows
	function automatic logic [31:0] page_val(input logic [7:0] p);
		return {p ^ 8'h5a, p + 8'h40, ~p, p};
	endfunction

	// four pages from s, wrapping to page 00h at lim
	function automatic logic [127:0] exp_read(input logic [7:0] s, input logic [7:0] lim);
		logic [127:0] r;
		logic [7:0] p;
		r = '0;
		p = s;
		for (int i = 0; i < 4; i++) begin
			if (p < 8'h12) r[32*i+:32] = page_val(p);
			p = (p + 8'h01 >= lim) ? 8'h00 : p + 8'h01;
		end
		return r;
	endfunction

	// one request; with hold the answer is stalled so the fifo fills up
	task automatic xfer(input logic rd, input logic [7:0] pg, input logic cor, input logic hold);
		int n;
		@(negedge core_clk);
		req_valid = 1'b1;
		req_read = rd;
		req_page = pg;
		req_corrupt = cor;
		rx_hold = hold;
		@(negedge core_clk);
		req_valid = 1'b0;
		req_corrupt = 1'b0;
		cmp_val(32'(req_ready), 32'h0);
		if (hold) begin
			repeat (40) @(negedge core_clk);
			cmp_val(32'(busy), 32'h1);
			rx_hold = 1'b0;
		end
		n = 0;
		while (res_valid !== 1'b1 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		cmp_val(32'(res_valid), 32'h1);
		cmp_val(32'(res_timeout), 32'h0);
		cmp_val(32'(req_ready), 32'h1);
	endtask

	task automatic rd_ok(input logic [7:0] pg, input logic [7:0] lim, input logic hold);
		xfer(1'b1, pg, 1'b0, hold);
		cmp_val(32'({res_nak, res_crc_err, 3'b000, res_len}), 32'h10);
		cmp_data(res_data, exp_read(pg, lim));
	endtask

	task automatic rd_nak(input logic rd, input logic [7:0] pg, input logic cor);
		xfer(rd, pg, cor, 1'b0);
		cmp_val(32'({res_nak, res_code}), 32'({1'b1, 3'b000, cor}));
	endtask

	// answer held back past the reader's limit, then drained so the card frees up
	task automatic rd_tmo();
		int n;
		@(negedge core_clk);
		rx_hold = 1'b1;
		req_valid = 1'b1;
		req_read = 1'b0;
		@(negedge core_clk);
		req_valid = 1'b0;
		n = 0;
		while (res_valid !== 1'b1 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		cmp_val(32'(res_timeout), 32'h1);
		rx_hold = 1'b0;
		repeat (20) @(negedge core_clk);
		cmp_val(32'(busy), 32'h0);
	endtask

	// hang guard, well above the length of the sequence
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 8000) begin
			error_cnt++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		nrst = 1'b1;
		// pages past the last one are offered too and must be dropped
		for (int p = 0; p < 22; p++) begin
			@(negedge core_clk);
			load_valid = 1'b1;
			load_page = 8'(p);
			load_data = page_val(8'(p));
		end
		@(negedge core_clk);
		load_valid = 1'b0;
		xfer(1'b0, 8'h00, 1'b0, 1'b0);
		cmp_val(32'({res_nak, res_crc_err, 3'b000, res_len}), 32'h08);
		// bytes past the eight version bytes carry the crc and older data
		cmp_data({64'h0, res_data[63:0]}, {64'h0, VER});
		for (int i = 0; i < 6; i++) begin
			rd_ok(8'(i * 3 + ((i == 5) ? 2 : 0)), 8'h14, 1'b0);
		end
		rd_ok(8'h13, 8'h14, 1'b0);
		rd_nak(1'b1, 8'h14, 1'b0);
		rd_nak(1'b1, 8'hff, 1'b0);
		protection_start_page = 8'h08;
		rd_ok(8'h06, 8'h08, 1'b0);
		rd_nak(1'b1, 8'h08, 1'b0);
		rd_nak(1'b1, 8'h13, 1'b0);
		authenticated = 1'b1;
		rd_ok(8'h06, 8'h14, 1'b0);
		rd_ok(8'h11, 8'h14, 1'b0);
		rd_nak(1'b0, 8'h00, 1'b1);
		rd_nak(1'b1, 8'h02, 1'b1);
		rd_ok(8'h0f, 8'h14, 1'b1);
		rd_tmo();
		xfer(1'b0, 8'h00, 1'b0, 1'b0);
		cmp_data({64'h0, res_data[63:0]}, {64'h0, VER});
		test_done();
	end
endmodule
